// file: bal_pkg.sv
package bal_pkg;
    // ==========================================
    // Bus address and register map
    localparam logic [6:0] DEV_ADDR   = 7'h2c; // Arbitrary bus address
    localparam logic [7:0] OFS_BSTS   = 8'h50;
    localparam logic [7:0] OFS_BCFG   = 8'h54;
    localparam logic [7:0] OFS_ACFG   = 8'h55;
    localparam logic [7:0] OFS_LSTS   = 8'h5a;
    localparam logic [7:0] OFS_FLOW   = 8'h5d;
    // ==========================================
    // Field positions
    localparam int B_EXT    = 7;
    localparam int B_INTEN  = 6;
    localparam int B_REMOFF = 5;
    localparam int B_AUTOFF = 4;
    localparam int B_TDM    = 2;
    localparam int B_LOCAL  = 1;
    localparam int B_AUX    = 0;
    localparam int B_T2P    = 7;
    localparam int B_I2SOUT = 6;
    localparam int B_RTYPE  = 3;
    localparam int B_RAIF   = 2;
    localparam int B_RAVI   = 1;
    localparam int B_RACR   = 0;
    localparam int B_HINT   = 6;
    // ==========================================
    // Reset values and masks
    localparam logic [7:0] BCFG_RST   = 8'h00;
    localparam logic [7:0] BCFG_MASK  = 8'hf7;
    localparam logic [7:0] ACFG_RST   = 8'h0c;
    localparam logic [7:0] ACFG_MASK  = 8'hcf;
    localparam logic [7:0] LSTS_RST   = 8'h00;
    localparam logic [5:0] FLOW_RST   = 6'h06;
    localparam logic [1:0] PORT_SNGL  = 2'h1;
    localparam logic [1:0] PORT_NONE  = 2'h0;
    localparam logic [3:0] BIT_CNT_LAST = 4'h8;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_AACK, S_REG, S_RACKW, S_WDAT, S_WACK, S_RDAT, S_RACK
    } bal_state_t;
endpackage

// file: bal_ctrl_regs.sv
`timescale 1ns/1ns
module bal_ctrl_regs (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        strap_pin_a,
    input  wire logic        strap_pin_b,
    input  wire logic        hdmi_int_pending,
    input  wire logic        downstream_link_ready,
    input  wire logic        tx_active,
    input  wire logic        far_rx_locked,
    input  wire logic        input_data_recovering,
    input  wire logic        pll_locked,
    input  wire logic        input_clock_steady,
    input  wire logic [7:0]  meas_freq_mhz,
    input  wire logic [3:0]  audio_type,
    input  wire logic [7:0]  audio_frame_sum,
    input  wire logic [7:0]  video_frame_sum,
    input  wire logic [19:0] clock_regen_n,
    input  wire logic [19:0] clock_regen_cts,
    output logic             interrupt_out_n,
    output logic             internal_seq_en,
    output logic             receiver_setup_en,
    output logic             remote_id_load_en,
    output logic             tdm_audio_en,
    output logic             local_audio_sel,
    output logic             aux_audio_en,
    output logic             tdm_to_par_en,
    output logic             par_clock_sel,
    output logic             hdmi_i2s_out_en,
    output logic             audio_fifo_reset
);
    // ==========================================
    // Pin synchronisers
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] sa_sy;
    logic [1:0] sb_sy;
    logic       scl_p_q;
    logic       sda_p_q;

    always_ff @(posedge mclk)
    begin
        scl_sy  <= {scl_sy[0], scl_in};
        sda_sy  <= {sda_sy[0], sda_in};
        sa_sy   <= {sa_sy[0], strap_pin_a};
        sb_sy   <= {sb_sy[0], strap_pin_b};
        scl_p_q <= scl_sy[1];
        sda_p_q <= sda_sy[1];
    end

    wire scl_s   = scl_sy[1];
    wire sda_s   = sda_sy[1];
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_c  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // ==========================================
    // Serial control bus slave
    bal_pkg::bal_state_t st_q;
    bal_pkg::bal_state_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       rw_q;
    logic       rw_d;
    logic       mack_q;
    logic       mack_d;
    logic       wr_en;
    logic [7:0] rd_data;

    wire byte_done = (cnt_q == bal_pkg::BIT_CNT_LAST);

    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        tx_d   = tx_q;
        ptr_d  = ptr_q;
        rw_d   = rw_q;
        mack_d = mack_q;
        wr_en  = 1'b0;
        if (start_c)
        begin
            st_d  = bal_pkg::S_ADDR;
            cnt_d = 4'h0;
        end
        else if (stop_c)
            st_d = bal_pkg::S_IDLE;
        else if (scl_rise)
        begin
            if (st_q == bal_pkg::S_RACK)
                mack_d = ~sda_s;
            else if (st_q != bal_pkg::S_IDLE && st_q != bal_pkg::S_AACK &&
                     st_q != bal_pkg::S_RACKW && st_q != bal_pkg::S_WACK)
            begin
                sh_d  = {sh_q[6:0], sda_s};
                cnt_d = cnt_q + 4'h1;
            end
        end
        else if (scl_fall)
        begin
            unique case (st_q)
                bal_pkg::S_IDLE: ;
                bal_pkg::S_ADDR:
                    if (byte_done)
                    begin
                        rw_d = sh_q[0];
                        st_d = (sh_q[7:1] == bal_pkg::DEV_ADDR) ? bal_pkg::S_AACK : bal_pkg::S_IDLE;
                    end
                bal_pkg::S_AACK:
                begin
                    cnt_d = 4'h0;
                    if (rw_q)
                    begin
                        tx_d  = rd_data;
                        ptr_d = ptr_q + 8'h01;
                        st_d  = bal_pkg::S_RDAT;
                    end
                    else
                        st_d = bal_pkg::S_REG;
                end
                bal_pkg::S_REG:
                    if (byte_done)
                    begin
                        ptr_d = sh_q;
                        st_d  = bal_pkg::S_RACKW;
                    end
                bal_pkg::S_RACKW, bal_pkg::S_WACK:
                begin
                    cnt_d = 4'h0;
                    st_d  = bal_pkg::S_WDAT;
                end
                bal_pkg::S_WDAT:
                    if (byte_done)
                    begin
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                        st_d  = bal_pkg::S_WACK;
                    end
                bal_pkg::S_RDAT:
                    if (byte_done)
                        st_d = bal_pkg::S_RACK;
                    else
                        tx_d = {tx_q[6:0], 1'b0};
                bal_pkg::S_RACK:
                begin
                    cnt_d = 4'h0;
                    if (mack_q)
                    begin
                        tx_d  = rd_data;
                        ptr_d = ptr_q + 8'h01;
                        st_d  = bal_pkg::S_RDAT;
                    end
                    else
                        st_d = bal_pkg::S_IDLE;
                end
                default: st_d = bal_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q   <= bal_pkg::S_IDLE;
            cnt_q  <= 4'h0;
            sh_q   <= 8'h00;
            tx_q   <= 8'h00;
            ptr_q  <= 8'h00;
            rw_q   <= 1'b0;
            mack_q <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            tx_q   <= tx_d;
            ptr_q  <= ptr_d;
            rw_q   <= rw_d;
            mack_q <= mack_d;
        end
    end

    // Open-drain data line: only ever pulled low
    wire drive_low = (st_q == bal_pkg::S_AACK) || (st_q == bal_pkg::S_RACKW) ||
                     (st_q == bal_pkg::S_WACK) || (st_q == bal_pkg::S_RDAT && !tx_q[7]);
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_low;

    // ==========================================
    // Register file
    logic [7:0] bcfg_q;
    logic [7:0] acfg_q;
    logic [7:0] lsts_q;
    logic [5:0] flow_q;
    logic       hint_q;
    logic       strap_done_q;

    wire wr_bcfg = wr_en && (ptr_q == bal_pkg::OFS_BCFG);
    wire wr_acfg = wr_en && (ptr_q == bal_pkg::OFS_ACFG);
    wire wr_flow = wr_en && (ptr_q == bal_pkg::OFS_FLOW);

    // Status is sampled every cycle; a clock equal to the threshold counts as absent
    wire       tx_lock  = tx_active & far_rx_locked & input_data_recovering;
    wire [1:0] port_st  = tx_lock ? bal_pkg::PORT_SNGL : bal_pkg::PORT_NONE;
    wire       no_clk   = (meas_freq_mhz <= {2'b00, flow_q});
    wire [7:0] lsts_d   = {downstream_link_ready, tx_lock, port_st,
                           input_data_recovering, pll_locked, no_clk,
                           input_clock_steady};

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            bcfg_q       <= bal_pkg::BCFG_RST;
            acfg_q       <= bal_pkg::ACFG_RST;
            lsts_q       <= bal_pkg::LSTS_RST;
            flow_q       <= bal_pkg::FLOW_RST;
            hint_q       <= 1'b0;
            strap_done_q <= 1'b0;
        end
        else
        begin
            // Straps win over a bus write in the first cycle after reset
            strap_done_q <= 1'b1;
            if (!strap_done_q)
            begin
                bcfg_q[bal_pkg::B_EXT]    <= sb_sy[1];
                bcfg_q[bal_pkg::B_REMOFF] <= sb_sy[1];
                bcfg_q[bal_pkg::B_AUX]    <= sa_sy[1];
            end
            else if (wr_bcfg)
                bcfg_q <= sh_q & bal_pkg::BCFG_MASK;
            if (wr_acfg)
                acfg_q <= sh_q & bal_pkg::ACFG_MASK;
            if (wr_flow)
                flow_q <= sh_q[5:0];
            lsts_q <= lsts_d;
            hint_q <= hdmi_int_pending;
        end
    end

    assign rd_data = (ptr_q == bal_pkg::OFS_BCFG) ? bcfg_q :
                     (ptr_q == bal_pkg::OFS_ACFG) ? acfg_q :
                     (ptr_q == bal_pkg::OFS_LSTS) ? lsts_q :
                     (ptr_q == bal_pkg::OFS_FLOW) ? {2'b00, flow_q} :
                     (ptr_q == bal_pkg::OFS_BSTS) ? {1'b0, hint_q, 6'h00} : 8'h00;

    // ==========================================
    // Control outputs
    assign interrupt_out_n   = ~(bcfg_q[bal_pkg::B_INTEN] & hint_q);
    assign internal_seq_en   = ~bcfg_q[bal_pkg::B_EXT];
    assign receiver_setup_en = internal_seq_en & ~bcfg_q[bal_pkg::B_AUTOFF];
    assign remote_id_load_en = internal_seq_en & ~bcfg_q[bal_pkg::B_REMOFF];
    assign tdm_audio_en      = bcfg_q[bal_pkg::B_TDM];
    assign local_audio_sel   = bcfg_q[bal_pkg::B_LOCAL];
    assign aux_audio_en      = bcfg_q[bal_pkg::B_AUX];
    assign tdm_to_par_en     = acfg_q[bal_pkg::B_T2P];
    assign par_clock_sel     = acfg_q[bal_pkg::B_T2P];
    assign hdmi_i2s_out_en   = acfg_q[bal_pkg::B_I2SOUT] & ~bcfg_q[bal_pkg::B_LOCAL];

    // ==========================================
    // Audio FIFO reset on received-stream changes
    logic [3:0]  typ_p_q;
    logic [7:0]  aif_p_q;
    logic [7:0]  avi_p_q;
    logic [39:0] acr_p_q;
    logic        seen_q;
    logic        fifo_rst_q;

    wire chg_typ = seen_q && (audio_type != typ_p_q);
    wire chg_aif = seen_q && (audio_frame_sum != aif_p_q);
    wire chg_avi = seen_q && (video_frame_sum != avi_p_q);
    wire chg_acr = seen_q && ({clock_regen_n, clock_regen_cts} != acr_p_q);
    // Events are ignored while an external controller owns sequencing
    wire fifo_rst_d = internal_seq_en &
                      ((acfg_q[bal_pkg::B_RTYPE] & chg_typ) |
                       (acfg_q[bal_pkg::B_RAIF]  & chg_aif) |
                       (acfg_q[bal_pkg::B_RAVI]  & chg_avi) |
                       (acfg_q[bal_pkg::B_RACR]  & chg_acr));

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            typ_p_q    <= 4'h0;
            aif_p_q    <= 8'h00;
            avi_p_q    <= 8'h00;
            acr_p_q    <= 40'h0;
            seen_q     <= 1'b0;
            fifo_rst_q <= 1'b0;
        end
        else
        begin
            typ_p_q    <= audio_type;
            aif_p_q    <= audio_frame_sum;
            avi_p_q    <= video_frame_sum;
            acr_p_q    <= {clock_regen_n, clock_regen_cts};
            seen_q     <= 1'b1;
            fifo_rst_q <= fifo_rst_d;
        end
    end

    assign audio_fifo_reset = fifo_rst_q;
endmodule // bal_ctrl_regs

// file: bal_host_model.sv
`timescale 1ns/1ns
// ==========================================
// Bus host model, open-drain data with pull-up
module bal_host_model (
    input  wire logic mclk,
    input  wire logic sda_out,
    input  wire logic sda_oe_n,
    output logic      scl_in,
    output logic      sda_in
);
    logic       drv = 1'b1;
    logic [7:0] nacks = 8'h00;
    initial scl_in = 1'b1;
    assign sda_in = drv & (sda_oe_n | sda_out);
    task automatic st(input logic c, input logic d);
        @(negedge mclk);
        scl_in = c;
        drv = d;
        repeat (4) @(negedge mclk);
    endtask
    task automatic bt(input logic b, output logic r);
        st(1'b0, drv);
        st(1'b0, b);
        st(1'b1, b);
        r = sda_in;
    endtask
    task automatic sta();
        st(1'b0, drv);
        st(1'b0, 1'b1);
        st(1'b1, 1'b1);
        st(1'b1, 1'b0);
    endtask
    task automatic sto();
        st(1'b0, drv);
        st(1'b0, 1'b0);
        st(1'b1, 1'b0);
        st(1'b1, 1'b1);
    endtask
    // Ninth bit: released and checked for ack, or a master nack
    task automatic xb(input logic [7:0] d, input logic chk, output logic [7:0] r);
        logic k;
        for (int i = 7; i >= 0; i--)
            bt(d[i], r[i]);
        bt(1'b1, k);
        if (chk && k !== 1'b0)
            nacks++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        sta();
        xb({bal_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
        xb(a, 1'b1, r);
        xb(d, 1'b1, r);
        sto();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        sta();
        xb({bal_pkg::DEV_ADDR, 1'b0}, 1'b1, r);
        xb(a, 1'b1, r);
        sta();
        xb({bal_pkg::DEV_ADDR, 1'b1}, 1'b1, r);
        xb(8'hff, 1'b0, d);
        sto();
    endtask
endmodule // bal_host_model

// file: bal_ctrl_regs_sva.sv
`timescale 1ns/1ns
// ==========================================
// Port checker
module bal_ctrl_regs_sva (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        scl_in,
    input wire logic        hdmi_int_pending,
    input wire logic [3:0]  audio_type,
    input wire logic [7:0]  audio_frame_sum,
    input wire logic [7:0]  video_frame_sum,
    input wire logic [19:0] clock_regen_n,
    input wire logic [19:0] clock_regen_cts,
    input wire logic        interrupt_out_n,
    input wire logic        internal_seq_en,
    input wire logic        receiver_setup_en,
    input wire logic        tdm_audio_en,
    input wire logic        local_audio_sel,
    input wire logic        tdm_to_par_en,
    input wire logic        par_clock_sel,
    input wire logic        hdmi_i2s_out_en,
    input wire logic        audio_fifo_reset
);
    logic [59:0] evt;
    assign evt = {audio_type, audio_frame_sum, video_frame_sum, clock_regen_n, clock_regen_cts};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_int_pin_cause: assert property (!interrupt_out_n |-> $past(hdmi_int_pending))
        else $error("interrupt pin low without pending");
    a_int_pin_clear: assert property ($fell(hdmi_int_pending) |=> interrupt_out_n)
        else $error("interrupt pin not released");
    a_setup_needs_seq: assert property (!internal_seq_en |-> !receiver_setup_en)
        else $error("receiver setup under external control");
    a_i2s_hdmi_only: assert property (hdmi_i2s_out_en |-> !local_audio_sel)
        else $error("hdmi i2s output with local source");
    a_par_clock_follow: assert property (par_clock_sel == tdm_to_par_en)
        else $error("parallel clock select differs");
    a_fifo_reset_cause: assert property (audio_fifo_reset |-> $past(evt) != $past(evt, 2))
        else $error("fifo reset without event");
    a_fifo_ext_off: assert property (audio_fifo_reset |-> $past(internal_seq_en))
        else $error("fifo reset under external control");
    a_cfg_bus_only: assert property ($changed({tdm_audio_en, local_audio_sel}) |-> !scl_in)
        else $error("config changed outside bus write");
    a_par_bus_only: assert property ($changed(tdm_to_par_en) |-> !scl_in)
        else $error("converter enable changed outside bus write");
    c_fifo: cover property (audio_fifo_reset);
    c_int: cover property (!interrupt_out_n);
    c_ext: cover property (!internal_seq_en);
endmodule // bal_ctrl_regs_sva
bind bal_ctrl_regs bal_ctrl_regs_sva bal_ctrl_regs_sva_inst (.mclk(mclk), .srst(srst), .scl_in(scl_in),
    .hdmi_int_pending(hdmi_int_pending), .audio_type(audio_type), .audio_frame_sum(audio_frame_sum),
    .video_frame_sum(video_frame_sum), .clock_regen_n(clock_regen_n), .clock_regen_cts(clock_regen_cts),
    .interrupt_out_n(interrupt_out_n), .internal_seq_en(internal_seq_en), .receiver_setup_en(receiver_setup_en),
    .tdm_audio_en(tdm_audio_en), .local_audio_sel(local_audio_sel), .tdm_to_par_en(tdm_to_par_en),
    .par_clock_sel(par_clock_sel), .hdmi_i2s_out_en(hdmi_i2s_out_en), .audio_fifo_reset(audio_fifo_reset));

// file: bal_ctrl_regs_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) if ((g) !== (e)) begin $display("mismatch %s exp %h got %h", nm, e, g); errors++; end n_checks++;
// ==========================================
// Testbench top
module bal_ctrl_regs_tb_top;
    logic        mclk = 1'b0, srst = 1'b1, scl_in, sda_in, sda_out, sda_oe_n;
    logic        strap_pin_a = 1'b1, strap_pin_b = 1'b0, hdmi_int_pending = 1'b0;
    logic        downstream_link_ready = 1'b0, tx_active = 1'b0, far_rx_locked = 1'b0;
    logic        input_data_recovering = 1'b0, pll_locked = 1'b0, input_clock_steady = 1'b0;
    logic [7:0]  meas_freq_mhz = 8'h08, audio_frame_sum = 8'h00, video_frame_sum = 8'h00, q;
    logic [3:0]  audio_type = 4'h0;
    logic [19:0] clock_regen_n = 20'h00000, clock_regen_cts = 20'h00000;
    logic        interrupt_out_n, internal_seq_en, receiver_setup_en, remote_id_load_en, tdm_audio_en;
    logic        local_audio_sel, aux_audio_en, tdm_to_par_en, par_clock_sel, hdmi_i2s_out_en, audio_fifo_reset;
    int          errors = 0, n_checks = 0;
    wire logic [9:0] outv = {interrupt_out_n, internal_seq_en, receiver_setup_en, remote_id_load_en,
        tdm_audio_en, local_audio_sel, aux_audio_en, tdm_to_par_en, par_clock_sel, hdmi_i2s_out_en};
    always #5 mclk = ~mclk;
    bal_ctrl_regs bal_ctrl_regs_inst (.mclk(mclk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b),
        .hdmi_int_pending(hdmi_int_pending), .downstream_link_ready(downstream_link_ready),
        .tx_active(tx_active), .far_rx_locked(far_rx_locked), .input_data_recovering(input_data_recovering),
        .pll_locked(pll_locked), .input_clock_steady(input_clock_steady), .meas_freq_mhz(meas_freq_mhz),
        .audio_type(audio_type), .audio_frame_sum(audio_frame_sum), .video_frame_sum(video_frame_sum),
        .clock_regen_n(clock_regen_n), .clock_regen_cts(clock_regen_cts), .interrupt_out_n(interrupt_out_n),
        .internal_seq_en(internal_seq_en), .receiver_setup_en(receiver_setup_en),
        .remote_id_load_en(remote_id_load_en), .tdm_audio_en(tdm_audio_en), .local_audio_sel(local_audio_sel),
        .aux_audio_en(aux_audio_en), .tdm_to_par_en(tdm_to_par_en), .par_clock_sel(par_clock_sel),
        .hdmi_i2s_out_en(hdmi_i2s_out_en), .audio_fifo_reset(audio_fifo_reset));
    bal_host_model bal_host_model_inst (.mclk(mclk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .scl_in(scl_in), .sda_in(sda_in));
    task automatic print_verdict();
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rst();
        @(negedge mclk);
        srst = 1'b1;
        repeat (6) @(negedge mclk);
        srst = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        bal_host_model_inst.rd(a, q);
        `CHK("register", e, q)
    endtask
    task automatic outs(input logic [9:0] e);
        @(negedge mclk);
        `CHK("outputs", e, outv)
    endtask
    task automatic stat(input logic [5:0] v, input logic [7:0] f, input logic [7:0] e);
        @(negedge mclk);
        {downstream_link_ready, tx_active, far_rx_locked, input_data_recovering, pll_locked, input_clock_steady} = v;
        meas_freq_mhz = f;
        rc(bal_pkg::OFS_LSTS, e);
    endtask
    // Change one event source, then look at the cycle after the sampling edge
    task automatic ev(input int j, input logic e);
        @(negedge mclk);
        case (j)
            0: clock_regen_cts = clock_regen_cts + 20'h00001;
            1: video_frame_sum = video_frame_sum + 8'h01;
            2: audio_frame_sum = audio_frame_sum + 8'h01;
            default: audio_type = audio_type + 4'h1;
        endcase
        @(negedge mclk);
        `CHK("fifo_reset", e, audio_fifo_reset)
    endtask
    initial
    begin
        repeat (100000) @(posedge mclk);
        errors++;
        print_verdict();
    end
    initial
    begin
        rst();
        rc(bal_pkg::OFS_BCFG, 8'h01);
        rc(bal_pkg::OFS_ACFG, 8'h0c);
        rc(bal_pkg::OFS_LSTS, 8'h00);
        rc(bal_pkg::OFS_FLOW, 8'h06);
        outs(10'b1111001000);
        hdmi_int_pending = 1'b1;
        bal_host_model_inst.wr(bal_pkg::OFS_BCFG, 8'hff);
        rc(bal_pkg::OFS_BCFG, 8'hf7);
        outs(10'b0000111000);
        rc(bal_pkg::OFS_BSTS, 8'h40);
        hdmi_int_pending = 1'b0;
        outs(10'b1000111000);
        bal_host_model_inst.wr(bal_pkg::OFS_BCFG, 8'h10);
        outs(10'b1101000000);
        bal_host_model_inst.wr(bal_pkg::OFS_ACFG, 8'hff);
        rc(bal_pkg::OFS_ACFG, 8'hcf);
        outs(10'b1101000111);
        bal_host_model_inst.wr(bal_pkg::OFS_BCFG, 8'h02);
        outs(10'b1111010110);
        bal_host_model_inst.wr(bal_pkg::OFS_BCFG, 8'h00);
        bal_host_model_inst.wr(bal_pkg::OFS_LSTS, 8'hff);
        rc(bal_pkg::OFS_LSTS, 8'h00);
        rc(8'h60, 8'h00);
        stat(6'h3f, 8'h06, 8'hdf);
        stat(6'h1d, 8'h07, 8'h59);
        stat(6'h2b, 8'h06, 8'h87);
        bal_host_model_inst.wr(bal_pkg::OFS_FLOW, 8'h10);
        stat(6'h00, 8'h10, 8'h02);
        stat(6'h00, 8'h11, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            bal_host_model_inst.wr(bal_pkg::OFS_ACFG, 8'h01 << k);
            for (int j = 0; j < 4; j++)
                ev(j, 1'(j == k));
        end
        bal_host_model_inst.wr(bal_pkg::OFS_BCFG, 8'h80);
        ev(3, 1'b0);
        strap_pin_a = 1'b0;
        strap_pin_b = 1'b1;
        rst();
        strap_pin_a = 1'b1;
        rc(bal_pkg::OFS_BCFG, 8'ha0);
        outs(10'b1000000000);
        `CHK("acks", 8'h00, bal_host_model_inst.nacks)
        print_verdict();
    end
endmodule // bal_ctrl_regs_tb_top
